// File: rtl/cms_pkg.sv
// Constants, field layout and carrier types for the clock multiplier and source select block
package cms_pkg;
	// Clock rate and multiplier warm-up time
	localparam int CLK_MHZ = 100;
	localparam int WARM_US = 5;
	localparam int WARM_CYCLES = WARM_US * CLK_MHZ;

	// Register addresses in the special function register space
	localparam logic [7:0] ADDR_MUL_CTRL = 8'hB9;
	localparam logic [7:0] ADDR_CLK_SEL = 8'hA9;
	localparam logic [7:0] MUL_CTRL_RESET = 8'h00;
	localparam logic [7:0] CLK_SEL_RESET = 8'h00;
	localparam logic [7:0] MUL_CTRL_WMASK = 8'hC3;
	localparam logic [7:0] CLK_SEL_WMASK = 8'h73;
	localparam logic [7:0] RDATA_NONE = 8'h00;

	// Field positions
	localparam int MUL_EN_BIT = 7;
	localparam int MUL_INIT_BIT = 6;
	localparam int MUL_RDY_BIT = 5;
	localparam int MUL_SEL_LSB = 0;
	localparam int SYS_SRC_LSB = 0;
	localparam int USB_SRC_LSB = 4;

	// Multiplier input codes
	localparam logic [1:0] MSEL_INT = 2'h0;
	localparam logic [1:0] MSEL_EXT = 2'h1;
	localparam logic [1:0] MSEL_EXT_DIV2 = 2'h2;

	// System clock source codes
	localparam logic [1:0] SYS_INT = 2'h0;
	localparam logic [1:0] SYS_EXT = 2'h1;
	localparam logic [1:0] SYS_MUL_DIV2 = 2'h2;

	// USB clock source codes
	localparam logic [2:0] USB_MUL = 3'h0;
	localparam logic [2:0] USB_INT_DIV2 = 3'h1;
	localparam logic [2:0] USB_EXT = 3'h2;
	localparam logic [2:0] USB_EXT_DIV2 = 3'h3;
	localparam logic [2:0] USB_INT_DIV4 = 3'h4;
	localparam logic [2:0] USB_EXT_DIV4 = 3'h5;

	// Divider terminal count
	localparam logic [1:0] DIV4_LAST = 2'h3;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} cms_sfr_req_t;

	// Multiplier bring-up states
	typedef enum logic [3:0] {
		MUL_OFF = 4'h1,
		MUL_WARM = 4'h2,
		MUL_LOCK = 4'h4,
		MUL_READY = 4'h8
	} cms_mul_state_t;
endpackage : cms_pkg

// File: rtl/cms_mul_core.sv
// Four-times multiplier core: tick multiplier with warm-up, lock and ready status
`timescale 1ns/1ps
module cms_mul_core #(
	parameter int PW = 8,
	parameter int LOCK_TICKS = 4,
	parameter int WARM_CYCLES = cms_pkg::WARM_CYCLES
) (
	input wire logic clock, // System clock
	input wire logic nrst, // Synchronous reset, active low
	input wire logic enable, // Power-up request
	input wire logic init, // Start of initialisation
	input wire logic in_tick, // Selected input rate pulse
	output logic out_tick, // Four pulses per input period
	output logic ready // Output stabilised
);
	localparam int WW = 16;
	localparam logic [WW-1:0] WARM_LAST = WW'(WARM_CYCLES - 1);
	localparam logic [7:0] LOCK_LAST = 8'(LOCK_TICKS - 1);
	localparam logic [PW-1:0] PH_MAX = '1;

	cms_pkg::cms_mul_state_t state_q, state_d;
	logic [WW-1:0] warm_q, warm_d;
	logic [7:0] lock_q, lock_d;
	logic [PW-1:0] phase_q, phase_d, period_q, period_d;
	logic [PW-1:0] q1, q2, q3, ph1;
	logic emit, tick_d, ready_d;

	// Period measure, quarter-period pulses and bring-up sequencing
	always_comb begin
		state_d = state_q;
		warm_d = warm_q;
		lock_d = lock_q;
		phase_d = phase_q;
		period_d = period_q;
		tick_d = 1'b0;
		ph1 = PW'(phase_q + 1'b1);
		q1 = period_q >> 2;
		q2 = q1 << 1;
		q3 = PW'(q2 + q1);
		if (in_tick) begin
			phase_d = '0;
			period_d = ph1;
		end else if (phase_q != PH_MAX) begin
			phase_d = ph1;
		end
		emit = in_tick || ((q1 != '0) && (ph1 == q1 || ph1 == q2 || ph1 == q3));
		case (state_q)
			cms_pkg::MUL_OFF: begin
				warm_d = '0;
				lock_d = '0;
				state_d = cms_pkg::MUL_WARM;
			end
			cms_pkg::MUL_WARM: begin
				lock_d = '0;
				if (warm_q != WARM_LAST) begin
					warm_d = WW'(warm_q + 1'b1);
				end else if (init) begin
					state_d = cms_pkg::MUL_LOCK;
				end
			end
			cms_pkg::MUL_LOCK: begin
				tick_d = emit;
				if (in_tick) begin
					if (lock_q == LOCK_LAST) begin
						state_d = cms_pkg::MUL_READY;
					end else begin
						lock_d = 8'(lock_q + 1'b1);
					end
				end
			end
			cms_pkg::MUL_READY: begin
				tick_d = emit;
			end
			default: begin
				state_d = cms_pkg::MUL_OFF;
			end
		endcase
		// Disable or a zero write drops back to off; clearing init drops back to warm
		if (!enable) begin
			state_d = cms_pkg::MUL_OFF;
			tick_d = 1'b0;
		end else if (!init && (state_q == cms_pkg::MUL_LOCK || state_q == cms_pkg::MUL_READY)) begin
			state_d = cms_pkg::MUL_WARM;
			tick_d = 1'b0;
		end
		ready_d = (state_d == cms_pkg::MUL_READY);
	end

	// State registers
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_q <= cms_pkg::MUL_OFF;
			warm_q <= '0;
			lock_q <= '0;
			phase_q <= '0;
			period_q <= '0;
			out_tick <= 1'b0;
			ready <= 1'b0;
		end else begin
			state_q <= state_d;
			warm_q <= warm_d;
			lock_q <= lock_d;
			phase_q <= phase_d;
			period_q <= period_d;
			out_tick <= tick_d;
			ready <= ready_d;
		end
	end

	rdy_off_a: assert property (@(posedge clock) disable iff (!nrst) !enable |=> !ready)
		else $error("ready stayed high after disable");
	mul_tick_a: assert property (@(posedge clock) disable iff (!nrst)
		(ready && enable && init && in_tick) |=> out_tick)
		else $error("no output pulse on input pulse while ready");
	rdy_cause_a: assert property (@(posedge clock) disable iff (!nrst)
		$rose(ready) |-> $past(init && enable, 1))
		else $error("ready rose without enable and init");
endmodule : cms_mul_core

// File: rtl/cms_clock_ctrl.sv
// Clock multiplier control, crystal valid flag and glitch-free system and USB source select
`timescale 1ns/1ps
// Operation
// - Multiplier gives four output pulses per input period, 12 MHz becomes 48 MHz.
// - Multiplier output divided by two is a system clock source.
// - Input select bits 1..0: internal, external, external halved, reserved.
// - Enable bit 7 powers the multiplier up; clearing it shuts it down.
// - After over 5 us, writing enable plus init bit 6 starts initialisation.
// - Read-only ready bit 5 reads one once the output is stable.
// - Internal oscillator is usable at once, with no settling wait.
// - Crystal valid flag is set by hardware once the external oscillator settles.
// - System source field selects the clock; code 01 runs it from external.
// - External oscillator still feeds USB while internal clocks the system.
// - System source may switch at run time to an enabled settled source.
// - Three-bit USB field picks multiplier, external, divided internal or divided external.
module cms_clock_ctrl #(
	parameter int XTAL_SETTLE_TICKS = 1024,
	parameter int LOCK_TICKS = 4
) (
	input wire logic clock, // System clock, 100 MHz
	input wire logic nrst, // Synchronous reset, active low
	input wire cms_pkg::cms_sfr_req_t sfr, // Register port request
	output logic [7:0] sfr_rdata, // Read data, valid cycle after rd
	input wire logic int_osc_tick, // Internal oscillator rate pulse
	input wire logic ext_osc_tick, // External oscillator rate pulse
	input wire logic ext_osc_enable, // External oscillator running
	output logic sys_clk_en, // System clock rate pulse
	output logic usb_clk_en, // USB function clock rate pulse
	output logic crystal_valid_flag // External oscillator settled
);
	localparam int XW = 16;
	// Count saturates at the full settle count, so the flag needs every pulse
	localparam logic [XW-1:0] XTAL_LAST = XW'(XTAL_SETTLE_TICKS);

	logic [7:0] mul_ctrl_q, mul_ctrl_d, clk_sel_q, clk_sel_d, rdata_d;
	logic [1:0] src_tick, div2_tick, div4_tick;
	logic [1:0] div_cnt_q [2];
	logic [1:0] div_cnt_d [2];
	logic mul_in_tick, mul_tick, mul_ready, mdiv_q, mdiv_d, mul_div2_tick;
	logic [1:0] mul_sel, sys_req, sys_act_q, sys_act_d;
	logic [2:0] usb_req, usb_act_q, usb_act_d;
	logic [3:0] sys_srcs;
	logic [7:0] usb_srcs;
	logic sys_en_d, usb_en_d;
	logic [XW-1:0] xtal_cnt_q, xtal_cnt_d;
	logic xvalid_d;

	// Register writes, read-back and unmapped reads
	always_comb begin
		mul_ctrl_d = mul_ctrl_q;
		clk_sel_d = clk_sel_q;
		rdata_d = sfr_rdata;
		if (sfr.wr && sfr.addr == cms_pkg::ADDR_MUL_CTRL) begin
			mul_ctrl_d = sfr.wdata & cms_pkg::MUL_CTRL_WMASK;
		end
		if (sfr.wr && sfr.addr == cms_pkg::ADDR_CLK_SEL) begin
			clk_sel_d = sfr.wdata & cms_pkg::CLK_SEL_WMASK;
		end
		if (sfr.rd) begin
			case (sfr.addr)
				cms_pkg::ADDR_MUL_CTRL: begin
					rdata_d = mul_ctrl_q;
					rdata_d[cms_pkg::MUL_RDY_BIT] = mul_ready;
				end
				cms_pkg::ADDR_CLK_SEL: rdata_d = clk_sel_q;
				default: rdata_d = cms_pkg::RDATA_NONE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			mul_ctrl_q <= cms_pkg::MUL_CTRL_RESET;
			clk_sel_q <= cms_pkg::CLK_SEL_RESET;
			sfr_rdata <= cms_pkg::RDATA_NONE;
		end else begin
			mul_ctrl_q <= mul_ctrl_d;
			clk_sel_q <= clk_sel_d;
			sfr_rdata <= rdata_d;
		end
	end

	// Divide-by-two and divide-by-four of internal and external oscillator
	assign src_tick = {ext_osc_tick, int_osc_tick};
	for (genvar i = 0; i < 2; i++) begin : g_div
		always_comb begin
			div_cnt_d[i] = div_cnt_q[i];
			if (src_tick[i]) begin
				div_cnt_d[i] = 2'(div_cnt_q[i] + 1'b1);
			end
		end
		always_ff @(posedge clock) begin
			if (!nrst) begin
				div_cnt_q[i] <= '0;
			end else begin
				div_cnt_q[i] <= div_cnt_d[i];
			end
		end
		assign div2_tick[i] = src_tick[i] && div_cnt_q[i][0];
		assign div4_tick[i] = src_tick[i] && (div_cnt_q[i] == cms_pkg::DIV4_LAST);
	end

	// Multiplier input select, reserved code feeds nothing
	assign mul_sel = mul_ctrl_q[cms_pkg::MUL_SEL_LSB +: 2];
	always_comb begin
		case (mul_sel)
			cms_pkg::MSEL_INT: mul_in_tick = int_osc_tick;
			cms_pkg::MSEL_EXT: mul_in_tick = ext_osc_tick;
			cms_pkg::MSEL_EXT_DIV2: mul_in_tick = div2_tick[1];
			default: mul_in_tick = 1'b0;
		endcase
	end

	cms_mul_core #(
		.PW(8),
		.LOCK_TICKS(LOCK_TICKS),
		.WARM_CYCLES(cms_pkg::WARM_CYCLES)
	) u_mul (
		.clock(clock),
		.nrst(nrst),
		.enable(mul_ctrl_q[cms_pkg::MUL_EN_BIT]),
		.init(mul_ctrl_q[cms_pkg::MUL_INIT_BIT]),
		.in_tick(mul_in_tick),
		.out_tick(mul_tick),
		.ready(mul_ready)
	);

	// Halved multiplier rate for the system clock
	always_comb begin
		mdiv_d = mdiv_q;
		if (mul_tick) begin
			mdiv_d = !mdiv_q;
		end
	end
	assign mul_div2_tick = mul_tick && mdiv_q;

	// Candidate pulses per source code; external stays usable for USB at all times
	assign sys_srcs = {1'b0, mul_div2_tick, ext_osc_tick, int_osc_tick};
	assign usb_srcs = {2'b00, div4_tick[1], div4_tick[0], div2_tick[1], ext_osc_tick,
		div2_tick[0], mul_tick};
	assign sys_req = clk_sel_q[cms_pkg::SYS_SRC_LSB +: 2];
	assign usb_req = clk_sel_q[cms_pkg::USB_SRC_LSB +: 3];

	// Switch only on a pulse of the new source, output held quiet meanwhile
	always_comb begin
		sys_act_d = sys_act_q;
		usb_act_d = usb_act_q;
		sys_en_d = 1'b0;
		usb_en_d = 1'b0;
		if (sys_req != sys_act_q) begin
			if (sys_srcs[sys_req]) begin
				sys_act_d = sys_req;
			end
		end else begin
			sys_en_d = sys_srcs[sys_act_q];
		end
		if (usb_req != usb_act_q) begin
			if (usb_srcs[usb_req]) begin
				usb_act_d = usb_req;
			end
		end else begin
			usb_en_d = usb_srcs[usb_act_q];
		end
	end

	// Crystal settle count over external pulses
	always_comb begin
		xtal_cnt_d = xtal_cnt_q;
		if (!ext_osc_enable) begin
			xtal_cnt_d = '0;
		end else if (ext_osc_tick && xtal_cnt_q != XTAL_LAST) begin
			xtal_cnt_d = XW'(xtal_cnt_q + 1'b1);
		end
		xvalid_d = ext_osc_enable && (xtal_cnt_d == XTAL_LAST);
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			mdiv_q <= 1'b0;
			sys_act_q <= cms_pkg::SYS_INT;
			usb_act_q <= cms_pkg::USB_MUL;
			sys_clk_en <= 1'b0;
			usb_clk_en <= 1'b0;
			xtal_cnt_q <= '0;
			crystal_valid_flag <= 1'b0;
		end else begin
			mdiv_q <= mdiv_d;
			sys_act_q <= sys_act_d;
			usb_act_q <= usb_act_d;
			sys_clk_en <= sys_en_d;
			usb_clk_en <= usb_en_d;
			xtal_cnt_q <= xtal_cnt_d;
			crystal_valid_flag <= xvalid_d;
		end
	end

	sys_int_a: assert property (@(posedge clock) disable iff (!nrst)
		(sys_req == cms_pkg::SYS_INT && sys_act_q == cms_pkg::SYS_INT && int_osc_tick)
		|=> sys_clk_en)
		else $error("internal pulse not passed to system clock");
	sys_ext_a: assert property (@(posedge clock) disable iff (!nrst)
		(sys_req == cms_pkg::SYS_EXT && sys_act_q == cms_pkg::SYS_EXT && ext_osc_tick)
		|=> sys_clk_en)
		else $error("external pulse not passed to system clock");
	sys_gap_a: assert property (@(posedge clock) disable iff (!nrst)
		(sys_req != sys_act_q) |=> !sys_clk_en)
		else $error("system clock pulsed during a switch");
	usb_gap_a: assert property (@(posedge clock) disable iff (!nrst)
		(usb_req != usb_act_q) |=> !usb_clk_en)
		else $error("usb clock pulsed during a switch");
	usb_mul_a: assert property (@(posedge clock) disable iff (!nrst)
		(usb_req == cms_pkg::USB_MUL && usb_act_q == cms_pkg::USB_MUL && mul_tick)
		|=> usb_clk_en)
		else $error("multiplier pulse not passed to usb clock");
	xtal_clr_a: assert property (@(posedge clock) disable iff (!nrst)
		!ext_osc_enable |=> !crystal_valid_flag)
		else $error("crystal valid high with oscillator off");
	rd_rdy_a: assert property (@(posedge clock) disable iff (!nrst)
		(sfr.rd && sfr.addr == cms_pkg::ADDR_MUL_CTRL)
		|=> sfr_rdata[cms_pkg::MUL_RDY_BIT] == $past(mul_ready))
		else $error("ready bit read-back wrong");
endmodule : cms_clock_ctrl

// File: tb/cms_osc_model.sv
// Oscillator sources model: internal and external rate pulses
`timescale 1ns/1ps
module cms_osc_model #(
	parameter int INT_PER = 12,
	parameter int EXT_PER = 8
) (
	input wire logic clock, // System clock
	input wire logic ext_on, // Switch the external oscillator on
	output logic int_osc_tick, // Internal oscillator pulse
	output logic ext_osc_tick, // External oscillator pulse
	output logic ext_osc_enable // External oscillator running
);
	int int_cnt;
	int ext_cnt;
	// Quiet lines at time zero
	initial begin
		int_cnt = 0;
		ext_cnt = 0;
		int_osc_tick = 1'b0;
		ext_osc_tick = 1'b0;
		ext_osc_enable = 1'b0;
	end
	// Internal oscillator runs from power-up with no start-up wait, exact as with recovery on
	always @(negedge clock) begin
		int_cnt <= (int_cnt == INT_PER - 1) ? 0 : int_cnt + 1;
		int_osc_tick <= (int_cnt == INT_PER - 1);
	end
	// External oscillator runs only while switched on, whatever clocks the system
	always @(negedge clock) begin
		ext_osc_enable <= ext_on;
		if (!ext_on) begin
			ext_cnt <= 0;
			ext_osc_tick <= 1'b0;
		end else begin
			ext_cnt <= (ext_cnt == EXT_PER - 1) ? 0 : ext_cnt + 1;
			ext_osc_tick <= (ext_cnt == EXT_PER - 1);
		end
	end
endmodule : cms_osc_model

// File: tb/tb.sv
// Self-checking bench for the clock multiplier and source select block
`timescale 1ns/1ps
module tb;
	localparam int INT_PER = 12;
	localparam int EXT_PER = 8;
	localparam int WIN = 480;
	localparam logic [7:0] MUL = cms_pkg::ADDR_MUL_CTRL;
	localparam logic [7:0] SEL = cms_pkg::ADDR_CLK_SEL;
	logic clock;
	logic nrst;
	logic ext_on;
	cms_pkg::cms_sfr_req_t sfr;
	logic [7:0] sfr_rdata;
	logic int_osc_tick;
	logic ext_osc_tick;
	logic ext_osc_enable;
	logic sys_clk_en;
	logic usb_clk_en;
	logic crystal_valid_flag;
	int bad_count;
	int num_checks;
	logic [9:0] cnt_usb;
	logic [9:0] cnt_sys;
	logic [7:0] rd_val;
	int usb_exp [8];
	int sys_exp [4];
	int mul_exp [3];
	logic [1:0] msel_code [3];
	cms_clock_ctrl #(.XTAL_SETTLE_TICKS(8), .LOCK_TICKS(2)) i_cms_clock_ctrl (
		.clock(clock), .nrst(nrst), .sfr(sfr), .sfr_rdata(sfr_rdata),
		.int_osc_tick(int_osc_tick), .ext_osc_tick(ext_osc_tick),
		.ext_osc_enable(ext_osc_enable), .sys_clk_en(sys_clk_en),
		.usb_clk_en(usb_clk_en), .crystal_valid_flag(crystal_valid_flag));
	cms_osc_model #(.INT_PER(INT_PER), .EXT_PER(EXT_PER)) i_cms_osc_model (
		.clock(clock), .ext_on(ext_on), .int_osc_tick(int_osc_tick),
		.ext_osc_tick(ext_osc_tick), .ext_osc_enable(ext_osc_enable));
	// Clock generator
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Compare one value and count it
	task automatic check_val(input logic [9:0] seen, input logic [9:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask : check_val
	// Verdict and end of run
	task automatic final_report;
		if (bad_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report
	// One-cycle write strobe
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		sfr.addr = a;
		sfr.wdata = d;
		sfr.wr = 1'b1;
		@(negedge clock);
		sfr.wr = 1'b0;
	endtask : sfr_write
	// One-cycle read strobe, data taken the cycle after
	task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		sfr.addr = a;
		sfr.rd = 1'b1;
		@(negedge clock);
		sfr.rd = 1'b0;
		d = sfr_rdata;
	endtask : sfr_read
	// Read and compare a register
	task automatic read_chk(input logic [7:0] a, input logic [7:0] exp);
		sfr_read(a, rd_val);
		check_val({2'h0, rd_val}, {2'h0, exp});
	endtask : read_chk
	// Count output pulses over a window
	task automatic count_clk(input int n);
		cnt_usb = 10'h000;
		cnt_sys = 10'h000;
		repeat (n) begin
			@(negedge clock);
			cnt_usb = cnt_usb + {9'h000, usb_clk_en};
			cnt_sys = cnt_sys + {9'h000, sys_clk_en};
		end
	endtask : count_clk
	// Documented bring-up sequence with bounded ready poll
	task automatic bring_up(input logic [1:0] s);
		int k;
		sfr_write(MUL, 8'h00);
		sfr_write(MUL, {6'h00, s});
		sfr_write(MUL, {6'h20, s});
		read_chk(MUL, {6'h20, s});
		repeat (cms_pkg::WARM_CYCLES + 10) @(negedge clock);
		sfr_write(MUL, {6'h30, s});
		k = 0;
		rd_val = 8'h00;
		while (rd_val[cms_pkg::MUL_RDY_BIT] !== 1'b1 && k < 100) begin
			sfr_read(MUL, rd_val);
			k++;
		end
		if (k == 100) begin
			bad_count++;
			final_report();
		end
		check_val({2'h0, rd_val}, {4'h3, 4'h8, s});
	endtask : bring_up
	// Watchdog against a hang
	initial begin
		repeat (100000) @(posedge clock);
		bad_count++;
		final_report();
	end
	// Main sequence
	initial begin
		msel_code = '{cms_pkg::MSEL_INT, cms_pkg::MSEL_EXT_DIV2, cms_pkg::MSEL_EXT};
		mul_exp = '{WIN * 4 / INT_PER, WIN * 2 / EXT_PER, WIN * 4 / EXT_PER};
		usb_exp = '{WIN * 4 / EXT_PER, WIN / (2 * INT_PER), WIN / EXT_PER,
			WIN / (2 * EXT_PER), WIN / (4 * INT_PER), WIN / (4 * EXT_PER), 0, 0};
		sys_exp = '{WIN / INT_PER, WIN / EXT_PER, WIN * 2 / EXT_PER, 0};
		bad_count = 0;
		num_checks = 0;
		nrst = 1'b0;
		ext_on = 1'b0;
		sfr = '0;
		repeat (20) @(negedge clock);
		nrst = 1'b1;
		// Reset values, unmapped place and write masks
		read_chk(MUL, 8'h00);
		read_chk(SEL, 8'h00);
		read_chk(8'h00, 8'h00);
		sfr_write(MUL, 8'h3C);
		read_chk(MUL, 8'h00);
		sfr_write(SEL, 8'hFF);
		read_chk(SEL, 8'h73);
		sfr_write(SEL, 8'h00);
		// Crystal valid after settling
		check_val({9'h000, crystal_valid_flag}, 10'h000);
		@(negedge clock);
		ext_on <= 1'b1;
		repeat (8 * EXT_PER) @(negedge clock);
		check_val({9'h000, crystal_valid_flag}, 10'h000);
		repeat (4 * EXT_PER) @(negedge clock);
		check_val({9'h000, crystal_valid_flag}, 10'h001);
		// Multiplier rate for the internal, external halved and external input codes, seen on the USB clock
		for (int m = 0; m < 3; m++) begin
			bring_up(msel_code[m]);
			repeat (64) @(negedge clock);
			count_clk(WIN);
			check_val(cnt_usb, 10'(mul_exp[m]));
		end
		// Every USB and system source code, switched at run time
		for (int i = 0; i < 8; i++) begin
			sfr_write(SEL, {1'b0, 3'(i), 2'h0, 2'(i)});
			repeat (96) @(negedge clock);
			count_clk(WIN);
			check_val(cnt_usb, 10'(usb_exp[i]));
			check_val(cnt_sys, 10'(sys_exp[i % 4]));
		end
		// Disable drops ready and stops the output
		sfr_write(SEL, 8'h00);
		repeat (16) @(negedge clock);
		count_clk(WIN);
		check_val(cnt_usb, 10'(usb_exp[0]));
		sfr_write(MUL, 8'h01);
		read_chk(MUL, 8'h01);
		repeat (8) @(negedge clock);
		count_clk(WIN);
		check_val(cnt_usb, 10'h000);
		sfr_write(MUL, 8'h00);
		read_chk(MUL, 8'h00);
		@(negedge clock);
		ext_on <= 1'b0;
		repeat (4) @(negedge clock);
		check_val({9'h000, crystal_valid_flag}, 10'h000);
		final_report();
	end
endmodule : tb
